/* File: power_switch_wake_control.sv */
// system power-state controller: switch presses, wake sources, os commands
`timescale 1ns/10ps
`include "pwr_consts.svh"
module power_switch_wake_control #(
  parameter int unsigned SHORT_CYCLES = `PWR_SHORT_CYCLES,
  parameter int unsigned LONG_CYCLES  = `PWR_LONG_CYCLES
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             nrst_i,
  // front panel switch
  input  wire logic             pwr_sw_n_i,
  // wake pins
  input  wire logic             lan_wake_i,
  input  wire logic             pme_n_i,
  input  wire logic             rtc_alarm_i,
  input  wire logic             usb_wake_i,
  input  wire logic             pcie_wake_n_i,
  // firmware options
  input  wire logic             fw_defaults_i,
  input  wire logic             fw_opt_wr_i,
  input  wire logic             fw_lan_s5_i,
  input  wire logic             fw_pme_s5_i,
  // os commands
  input  wire logic             os_cmd_valid_i,
  input  wire pwr_pkg::os_cmd_t os_cmd_state_i,
  output logic                  os_cmd_ack_o,
  // status
  output pwr_pkg::pstate_t      state_o,
  output logic                  wake_o,
  output logic                  fail_safe_o,
  output logic                  press_held_o,
  output logic [1:0]            s5_wake_en_o
);

  press_if pif ();

  press_timer #(
    .SHORT_CYCLES (SHORT_CYCLES),
    .LONG_CYCLES  (LONG_CYCLES)
  ) u_press_timer (
    .sys_clk_i  (sys_clk_i),
    .nrst_i     (nrst_i),
    .pwr_sw_n_i (pwr_sw_n_i),
    .pif        (pif)
  );

  // ****************************************
  // wake pin synchronisers
  // ****************************************
  logic [`WK_NUM-1:0] raw;
  logic [`WK_NUM-1:0] s1;
  logic [`WK_NUM-1:0] s2;
  logic [`WK_NUM-1:0] s3;
  logic [`WK_NUM-1:0] lvl;
  logic [`WK_NUM-1:0] next_lvl;
  logic [`WK_NUM-1:0] lvl_d;
  logic [`WK_NUM-1:0] evt;

  // active-low pins inverted before the chain so all bits are active high
  assign raw = {~pcie_wake_n_i, usb_wake_i, rtc_alarm_i, ~pme_n_i, lan_wake_i};

  always_comb begin
    next_lvl = lvl;
    for (int i = 0; i < `WK_NUM; i++) begin
      if (s2[i] == s3[i]) begin
        next_lvl[i] = s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      s1    <= '0;
      s2    <= '0;
      s3    <= '0;
      lvl   <= '0;
      lvl_d <= '0;
    end else begin
      s1    <= raw;
      s2    <= s1;
      s3    <= s2;
      lvl   <= next_lvl;
      lvl_d <= lvl;
    end
  end

  // a wake source counts on its rising edge; a held level does not repeat
  assign evt = lvl & ~lvl_d;

  // ****************************************
  // firmware s5 wake options
  // ****************************************
  logic lan_s5_en;
  logic pme_s5_en;
  logic next_lan_s5_en;
  logic next_pme_s5_en;

  always_comb begin
    next_lan_s5_en = lan_s5_en;
    next_pme_s5_en = pme_s5_en;
    if (fw_defaults_i) begin
      next_lan_s5_en = `S5_WAKE_EN_RST;
      next_pme_s5_en = `S5_WAKE_EN_RST;
    end else if (fw_opt_wr_i) begin
      next_lan_s5_en = fw_lan_s5_i;
      next_pme_s5_en = fw_pme_s5_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      lan_s5_en <= `S5_WAKE_EN_RST;
      pme_s5_en <= `S5_WAKE_EN_RST;
    end else begin
      lan_s5_en <= next_lan_s5_en;
      pme_s5_en <= next_pme_s5_en;
    end
  end

  assign s5_wake_en_o = {pme_s5_en, lan_s5_en};

  // ****************************************
  // power state machine
  // ****************************************
  pwr_pkg::pstate_t state;
  pwr_pkg::pstate_t next_state;
  logic             wake;
  logic             next_wake;
  logic             fsafe;
  logic             next_fsafe;
  logic             asleep;
  logic             in_s5;
  logic             wake_ok;
  logic             cmd_ok;

  function automatic pwr_pkg::pstate_t cmd_target(input pwr_pkg::os_cmd_t c);
    case (c)
      pwr_pkg::CMD_S1: cmd_target = pwr_pkg::ST_S1;
      pwr_pkg::CMD_S3: cmd_target = pwr_pkg::ST_S3;
      pwr_pkg::CMD_S4: cmd_target = pwr_pkg::ST_S4;
      pwr_pkg::CMD_S5: cmd_target = pwr_pkg::ST_S5;
      default:         cmd_target = pwr_pkg::ST_S0;
    endcase
  endfunction : cmd_target

  assign asleep = (state == pwr_pkg::ST_S1) || (state == pwr_pkg::ST_S3) || (state == pwr_pkg::ST_S4);
  assign in_s5  = (state == pwr_pkg::ST_S5);

  // usb only from S1 and S3
  // lan and pme from S5 only when enabled
  assign wake_ok = (asleep || in_s5) && (
                     evt[`WK_RTC] || evt[`WK_PCIE] ||
                     (evt[`WK_LAN] && (!in_s5 || lan_s5_en)) ||
                     (evt[`WK_PME] && (!in_s5 || pme_s5_en)) ||
                     (evt[`WK_USB] && ((state == pwr_pkg::ST_S1) || (state == pwr_pkg::ST_S3))));

  // os commands taken in working state while no press is pending
  // a held switch blocks every transition but the long press until it is released
  assign cmd_ok       = os_cmd_valid_i && (state == pwr_pkg::ST_S0) && !pif.held &&
                        !pif.short_press && !pif.long_press;
  assign os_cmd_ack_o = cmd_ok;

  always_comb begin
    next_state = state;
    next_wake  = 1'b0;
    next_fsafe = 1'b0;
    case (state)
      pwr_pkg::ST_S0: begin
        if (pif.long_press) begin
          next_state = pwr_pkg::ST_S5;
          next_fsafe = 1'b1;
        // short press puts the working system to sleep
        end else if (pif.short_press) begin
          next_state = pwr_pkg::ST_S1;
        end else if (cmd_ok) begin
          next_state = cmd_target(os_cmd_state_i);
        end
      end
      pwr_pkg::ST_S1, pwr_pkg::ST_S3, pwr_pkg::ST_S4: begin
        if (pif.long_press) begin
          next_state = pwr_pkg::ST_S5;
          next_fsafe = 1'b1;
        end else if (!pif.held && (pif.short_press || wake_ok)) begin
          next_state = pwr_pkg::ST_S0;
          next_wake  = 1'b1;
        end
      end
      pwr_pkg::ST_S5: begin
        // short press powers on from soft-off
        if (!pif.held && (pif.short_press || wake_ok)) begin
          next_state = pwr_pkg::ST_S0;
          next_wake  = 1'b1;
        end
      end
      default: next_state = pwr_pkg::ST_S5;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      state <= pwr_pkg::ST_S5;
      wake  <= 1'b0;
      fsafe <= 1'b0;
    end else begin
      state <= next_state;
      wake  <= next_wake;
      fsafe <= next_fsafe;
    end
  end

  assign state_o      = state;
  assign wake_o       = wake;
  assign fail_safe_o  = fsafe;
  assign press_held_o = pif.held;

  // ****************************************
  // checks
  // ****************************************
  sequence s_off_short;
    state == pwr_pkg::ST_S5 && pif.short_press;
  endsequence

  property p_short_on;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      s_off_short |=> state == pwr_pkg::ST_S0 && wake;
  endproperty
  a_short_on: assert property (p_short_on) else $error("short press did not power on");

  property p_short_sleep;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (state == pwr_pkg::ST_S0 && pif.short_press && !pif.long_press) |=> state == pwr_pkg::ST_S1;
  endproperty
  a_short_sleep: assert property (p_short_sleep) else $error("short press did not sleep");

  sequence s_long_in_on;
    (asleep || state == pwr_pkg::ST_S0) && pif.long_press;
  endsequence

  property p_long_off;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      s_long_in_on |=> state == pwr_pkg::ST_S5 && fsafe ##1 !fsafe;
  endproperty
  a_long_off: assert property (p_long_off) else $error("long press did not force off");

  property p_rtc_wake;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (asleep && evt[`WK_RTC] && !pif.held && !pif.long_press) |=> state == pwr_pkg::ST_S0;
  endproperty
  a_rtc_wake: assert property (p_rtc_wake) else $error("rtc alarm did not wake");

  property p_usb_ignored;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      ((state == pwr_pkg::ST_S4 || in_s5) && evt == (`WK_NUM'(1) << `WK_USB) &&
       !pif.short_press && !pif.long_press) |=> $stable(state);
  endproperty
  a_usb_ignored: assert property (p_usb_ignored) else $error("usb woke from S4 or S5");

  property p_s5_lan_gate;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (in_s5 && !lan_s5_en && evt == (`WK_NUM'(1) << `WK_LAN) && !pif.short_press) |=> in_s5;
  endproperty
  a_s5_lan_gate: assert property (p_s5_lan_gate) else $error("lan woke from S5 while disabled");

  property p_os_off;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (cmd_ok && os_cmd_state_i == pwr_pkg::CMD_S5) |=> in_s5 && !fsafe;
  endproperty
  a_os_off: assert property (p_os_off) else $error("os soft-off not carried out");

  property p_held_freeze;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (pif.held && !pif.long_press) |=> $stable(state);
  endproperty
  a_held_freeze: assert property (p_held_freeze) else $error("transition while switch held");

endmodule : power_switch_wake_control

/* File: pwr_consts.svh */
// constants for the power switch and wake controller
`ifndef PWR_CONSTS_SVH
`define PWR_CONSTS_SVH

// ****************************************
// timing
// ****************************************
`define PWR_CLK_HZ        10000000
`define PWR_SHORT_TIME_S  4
`define PWR_LONG_TIME_S   6
`define PWR_SHORT_CYCLES  (`PWR_SHORT_TIME_S * `PWR_CLK_HZ)
`define PWR_LONG_CYCLES   (`PWR_LONG_TIME_S * `PWR_CLK_HZ)
`define PWR_CNT_W         26

// ****************************************
// wake source bit positions
// ****************************************
`define WK_LAN 0
`define WK_PME 1
`define WK_RTC 2
`define WK_USB 3
`define WK_PCIE 4
`define WK_NUM 5

// ****************************************
// reset values
// ****************************************
`define S5_WAKE_EN_RST 1'b0

`endif

/* File: pwr_pkg.sv */
// types for the power switch and wake controller
package pwr_pkg;

  typedef enum logic [4:0] {
    ST_S0 = 5'h01,
    ST_S1 = 5'h02,
    ST_S3 = 5'h04,
    ST_S4 = 5'h08,
    ST_S5 = 5'h10
  } pstate_t;

  typedef enum logic [1:0] {
    CMD_S1 = 2'h0,
    CMD_S3 = 2'h1,
    CMD_S4 = 2'h2,
    CMD_S5 = 2'h3
  } os_cmd_t;

endpackage : pwr_pkg

/* File: press_if.sv */
// classified power switch presses between timer and controller
`timescale 1ns/10ps
interface press_if;
  logic short_press;
  logic long_press;
  logic held;
  modport timer (output short_press, output long_press, output held);
  modport ctrl  (input short_press, input long_press, input held);
endinterface : press_if

/* File: press_timer.sv */
// power switch synchroniser and press-duration classifier
`timescale 1ns/10ps
`include "pwr_consts.svh"
module press_timer #(
  parameter int unsigned CNT_W        = `PWR_CNT_W,
  parameter int unsigned SHORT_CYCLES = `PWR_SHORT_CYCLES,
  parameter int unsigned LONG_CYCLES  = `PWR_LONG_CYCLES
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // switch pin, low while pressed
  input  wire logic pwr_sw_n_i,
  // classified presses
  press_if.timer    pif
);

  localparam logic [CNT_W-1:0] SHORT_C = CNT_W'(SHORT_CYCLES);
  localparam logic [CNT_W-1:0] LONG_C  = CNT_W'(LONG_CYCLES);

  logic [2:0]       sync;
  logic [2:0]       next_sync;
  logic             pressed;
  logic             next_pressed;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             long_done;
  logic             next_long_done;
  logic             short_p;
  logic             next_short_p;
  logic             long_p;
  logic             next_long_p;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_sync      = {sync[1:0], pwr_sw_n_i};
    next_pressed   = pressed;
    // change accepted only when stages two and three agree
    if (sync[1] == sync[2]) begin
      next_pressed = ~sync[2];
    end
    next_cnt       = '0;
    if (pressed) begin
      next_cnt = (cnt == LONG_C) ? cnt : cnt + CNT_W'(1);
    end
    // long hold fires once, while still held
    next_long_p    = pressed && !long_done && (cnt == LONG_C);
    next_long_done = pressed && (long_done || next_long_p);
    // short press classified on release only
    next_short_p   = pressed && !next_pressed && !long_done && (cnt < SHORT_C);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      sync      <= 3'h7;
      pressed   <= 1'b0;
      cnt       <= '0;
      long_done <= 1'b0;
      short_p   <= 1'b0;
      long_p    <= 1'b0;
    end else begin
      sync      <= next_sync;
      pressed   <= next_pressed;
      cnt       <= next_cnt;
      long_done <= next_long_done;
      short_p   <= next_short_p;
      long_p    <= next_long_p;
    end
  end

  assign pif.short_press = short_p;
  assign pif.long_press  = long_p;
  assign pif.held        = pressed;

  // ****************************************
  // checks
  // ****************************************
  property p_short_cls;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      short_p |-> $past(cnt) < SHORT_C && !pressed && $past(pressed);
  endproperty
  a_short_cls: assert property (p_short_cls) else $error("short press not below threshold");

  property p_long_once;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      long_p |=> !long_p && long_done;
  endproperty
  a_long_once: assert property (p_long_once) else $error("long press fired twice");

  property p_long_cls;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      long_p |-> $past(cnt) == LONG_C && $past(pressed);
  endproperty
  a_long_cls: assert property (p_long_cls) else $error("long press before threshold");

  property p_no_early;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (pressed && !long_done) |-> !short_p;
  endproperty
  a_no_early: assert property (p_no_early) else $error("press classified while held");

endmodule : press_timer

/* File: pwr_partner.sv */
// far side model: power switch, wake pins and operating system
`timescale 1ns/10ps
module pwr_partner (
  // clock
  input  wire logic        sys_clk_i,
  // towards the controller
  output logic             pwr_sw_n_o,
  output logic [4:0]       wk_o,
  output logic             os_cmd_valid_o,
  output pwr_pkg::os_cmd_t os_cmd_state_o,
  // from the controller
  input  wire logic        os_cmd_ack_i
);
  initial begin
    pwr_sw_n_o     = 1'b1;
    wk_o           = 5'h00;
    os_cmd_valid_o = 1'b0;
    os_cmd_state_o = pwr_pkg::CMD_S1;
  end

  task automatic sw(input logic v);
    @(posedge sys_clk_i) pwr_sw_n_o <= v;
  endtask : sw

  // press for n cycles, release, then idle long enough for the debounce chain to settle
  task automatic hold_sw(input int n);
    sw(1'b0);
    repeat (n) @(posedge sys_clk_i);
    pwr_sw_n_o <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
  endtask : hold_sw

  // level held well past the sync chain, then dropped so it can retrigger
  task automatic pulse(input int src);
    @(posedge sys_clk_i) wk_o[src] <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    wk_o[src] <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
  endtask : pulse

  task automatic cmd(input pwr_pkg::os_cmd_t st, output logic got);
    got = 1'b0;
    @(posedge sys_clk_i);
    os_cmd_valid_o <= 1'b1;
    os_cmd_state_o <= st;
    for (int i = 0; i < 4 && !got; i++) begin
      @(posedge sys_clk_i);
      got = (os_cmd_ack_i === 1'b1);
    end
    os_cmd_valid_o <= 1'b0;
  endtask : cmd
endmodule : pwr_partner

/* File: power_switch_wake_control_tb.sv */
// self-checking bench for the power switch and wake controller
`timescale 1ns/10ps
`include "pwr_consts.svh"
module power_switch_wake_control_tb;
  localparam int LIMIT = 20000;
  logic             sys_clk, nrst, fw_defaults, fw_opt_wr, fw_lan_s5, fw_pme_s5;
  logic             sw_n, cmd_valid, ack, wake, fail, held, got;
  logic [4:0]       wk;
  logic             lan_w, pme_n, rtc_w, usb_w, pcie_n;
  logic [1:0]       en;
  pwr_pkg::os_cmd_t cmd_state;
  pwr_pkg::pstate_t state;
  int               n_errors, tests_run, n_wake, n_fail, w0, f0, cycles;
  pwr_pkg::os_cmd_t cmds [3] = '{pwr_pkg::CMD_S1, pwr_pkg::CMD_S3, pwr_pkg::CMD_S4};
  pwr_pkg::pstate_t sts  [3] = '{pwr_pkg::ST_S1, pwr_pkg::ST_S3, pwr_pkg::ST_S4};

  // ****************
  // instances
  // ****************
  pwr_partner far_u (.sys_clk_i(sys_clk), .pwr_sw_n_o(sw_n), .wk_o(wk), .os_cmd_valid_o(cmd_valid),
                     .os_cmd_state_o(cmd_state), .os_cmd_ack_i(ack));
  // short counts keep the run brief
  // pin polarity as on the board: pme and pcie wake are active low
  assign {pcie_n, usb_w, rtc_w, pme_n, lan_w} = {~wk[`WK_PCIE], wk[`WK_USB], wk[`WK_RTC], ~wk[`WK_PME], wk[`WK_LAN]};
  power_switch_wake_control #(.SHORT_CYCLES(20), .LONG_CYCLES(40)) dut_u (
    .sys_clk_i(sys_clk), .nrst_i(nrst), .pwr_sw_n_i(sw_n),
    .lan_wake_i(lan_w), .pme_n_i(pme_n), .rtc_alarm_i(rtc_w),
    .usb_wake_i(usb_w), .pcie_wake_n_i(pcie_n),
    .fw_defaults_i(fw_defaults), .fw_opt_wr_i(fw_opt_wr), .fw_lan_s5_i(fw_lan_s5), .fw_pme_s5_i(fw_pme_s5),
    .os_cmd_valid_i(cmd_valid), .os_cmd_state_i(cmd_state), .os_cmd_ack_o(ack),
    .state_o(state), .wake_o(wake), .fail_safe_o(fail), .press_held_o(held), .s5_wake_en_o(en));

  // ****************
  // clock, counters, checks
  // ****************
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (wake === 1'b1) n_wake++;
    if (fail === 1'b1) n_fail++;
    if (cycles == LIMIT) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // pulse counts since the last call pin the one-cycle width too
  task automatic ev(input string what, input pwr_pkg::pstate_t st, input int dw, input int df);
    @(negedge sys_clk);
    chk(what, 8'(state), 8'(st));
    chk({what, " wake"}, 8'(n_wake - w0), 8'(dw));
    chk({what, " fail"}, 8'(n_fail - f0), 8'(df));
    w0 = n_wake;
    f0 = n_fail;
  endtask : ev

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ****************
  // scenarios
  // ****************
  task automatic t_press;
    far_u.hold_sw(10);
    ev("on", pwr_pkg::ST_S0, 1, 0);
    far_u.hold_sw(10);
    ev("sleep", pwr_pkg::ST_S1, 0, 0);
    far_u.hold_sw(10);
    ev("resume", pwr_pkg::ST_S0, 1, 0);
    far_u.sw(1'b0);
    repeat (8) @(posedge sys_clk);
    far_u.cmd(pwr_pkg::CMD_S5, got);
    chk("ack while held", 8'(got), 8'h00);
    chk("held", 8'(held), 8'h01);
    far_u.sw(1'b1);
    repeat (8) @(posedge sys_clk);
    ev("after held", pwr_pkg::ST_S1, 0, 0);
    far_u.hold_sw(10);
    ev("back on", pwr_pkg::ST_S0, 1, 0);
    $display("test press done");
  endtask : t_press

  task automatic t_long;
    far_u.hold_sw(30);
    ev("between", pwr_pkg::ST_S0, 0, 0);
    far_u.hold_sw(60);
    ev("long on", pwr_pkg::ST_S5, 0, 1);
    far_u.hold_sw(10);
    far_u.hold_sw(10);
    ev("to sleep", pwr_pkg::ST_S1, 1, 0);
    far_u.hold_sw(60);
    ev("long sleep", pwr_pkg::ST_S5, 0, 1);
    far_u.hold_sw(60);
    ev("long off", pwr_pkg::ST_S5, 0, 0);
    far_u.hold_sw(10);
    ev("on again", pwr_pkg::ST_S0, 1, 0);
    $display("test long done");
  endtask : t_long

  task automatic t_sleep_wake;
    for (int c = 0; c < 3; c++) begin
      for (int s = 0; s < `WK_NUM; s++) begin
        far_u.cmd(cmds[c], got);
        chk("ack", 8'(got), 8'h01);
        ev("cmd", sts[c], 0, 0);
        far_u.pulse(s);
        if (s == `WK_USB && c == 2) begin
          ev("usb in s4", pwr_pkg::ST_S4, 0, 0);
          far_u.hold_sw(10);
        end
        ev("woken", pwr_pkg::ST_S0, 1, 0);
      end
    end
    $display("test sleep wake done");
  endtask : t_sleep_wake

  task automatic t_soft_off;
    far_u.cmd(pwr_pkg::CMD_S5, got);
    ev("soft off", pwr_pkg::ST_S5, 0, 0);
    far_u.cmd(pwr_pkg::CMD_S1, got);
    chk("ack off", 8'(got), 8'h00);
    for (int s = 0; s < 4; s++) begin
      far_u.pulse(s == 2 ? `WK_USB : s);
    end
    ev("no wake off", pwr_pkg::ST_S5, 0, 0);
    far_u.pulse(`WK_PCIE);
    ev("pcie off", pwr_pkg::ST_S0, 1, 0);
    @(posedge sys_clk);
    fw_opt_wr <= 1'b1;
    fw_lan_s5 <= 1'b1;
    fw_pme_s5 <= 1'b1;
    @(posedge sys_clk);
    fw_opt_wr <= 1'b0;
    @(negedge sys_clk);
    chk("enables", 8'(en), 8'h03);
    for (int s = 0; s < 3; s++) begin
      far_u.cmd(pwr_pkg::CMD_S5, got);
      far_u.pulse(s == 2 ? `WK_RTC : s);
      ev("wake off", pwr_pkg::ST_S0, 1, 0);
    end
    @(posedge sys_clk);
    fw_defaults <= 1'b1;
    fw_opt_wr   <= 1'b1;
    @(posedge sys_clk);
    fw_defaults <= 1'b0;
    fw_opt_wr   <= 1'b0;
    @(negedge sys_clk);
    chk("defaults", 8'(en), 8'h00);
    far_u.cmd(pwr_pkg::CMD_S5, got);
    far_u.pulse(`WK_LAN);
    ev("lan refused", pwr_pkg::ST_S5, 0, 0);
    $display("test soft off done");
  endtask : t_soft_off

  task automatic t_reset;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    ev("reset", pwr_pkg::ST_S5, 0, 0);
    chk("reset enables", 8'(en), 8'h00);
    chk("reset held", 8'(held), 8'h00);
    $display("test reset done");
  endtask : t_reset

  // lan enable alone, pme left off, then a reset in mid-run drops it again
  task automatic t_opt_reset;
    @(posedge sys_clk);
    fw_opt_wr <= 1'b1;
    fw_lan_s5 <= 1'b1;
    fw_pme_s5 <= 1'b0;
    @(posedge sys_clk);
    fw_opt_wr <= 1'b0;
    @(negedge sys_clk);
    chk("lan only", 8'(en), 8'h01);
    far_u.pulse(`WK_PME);
    ev("pme refused", pwr_pkg::ST_S5, 0, 0);
    far_u.pulse(`WK_LAN);
    ev("lan s5", pwr_pkg::ST_S0, 1, 0);
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    ev("mid reset", pwr_pkg::ST_S5, 0, 0);
    chk("mid reset enables", 8'(en), 8'h00);
    chk("mid reset held", 8'(held), 8'h00);
    far_u.hold_sw(10);
    ev("on after reset", pwr_pkg::ST_S0, 1, 0);
    $display("test options reset done");
  endtask : t_opt_reset

  initial begin
    {nrst, fw_defaults, fw_opt_wr, fw_lan_s5, fw_pme_s5} = 5'h00;
    {n_errors, tests_run, n_wake, n_fail, w0, f0, cycles} = '0;
    t_reset();
    t_press();
    t_long();
    t_sleep_wake();
    t_soft_off();
    t_opt_reset();
    end_of_test();
  end
endmodule : power_switch_wake_control_tb
